/* usmsc_consts.vh */
// Constants for the modem, SPI and gap-register block: offsets, field positions, resets, codes.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef USMSC_CONSTS_VH
`define USMSC_CONSTS_VH

// Register byte offsets.
`define USMSC_OFF_CTRL        8'h00
`define USMSC_OFF_MODE        8'h04
`define USMSC_OFF_STATUS      8'h14
`define USMSC_OFF_TXDATA      8'h1C
`define USMSC_OFF_GAP         8'h74
`define USMSC_OFF_WPMODE      8'hE4

// Command bits of the control command register.
`define USMSC_CMD_TXEN        6
`define USMSC_CMD_TXDIS       7
`define USMSC_CMD_TR_EN       16
`define USMSC_CMD_TR_DIS      17

// Mode register fields.
`define USMSC_MODE_LSB        0
`define USMSC_MODE_W          4
`define USMSC_MODE_MODEM      4'h3
`define USMSC_MODE_LONB       4'h9
`define USMSC_MODE_SPI_MST    4'hE
`define USMSC_MODE_SPI_SLV    4'hF
`define USMSC_DIV_LSB         8
`define USMSC_DIV_W           8
`define USMSC_MODE_RST        32'h0000_0000

// Status register bit positions.
`define USMSC_ST_TXRDY        1
`define USMSC_ST_TXEMPTY      9
`define USMSC_ST_RING_CHANGE_FLAG         16
`define USMSC_ST_SET_READY_CHANGE_FLAG        17
`define USMSC_ST_CARRIER_CHANGE_FLAG        18
`define USMSC_ST_CLEAR_TO_SEND_CHANGE_FLAG        19
`define USMSC_ST_RI           20
`define USMSC_ST_DSR          21
`define USMSC_ST_DCD          22
`define USMSC_ST_CTS          23
`define USMSC_ST_RXRDY        24

// Gap register and write protection.
`define USMSC_GAP_W           24
`define USMSC_GAP_RST         24'h00_0000
`define USMSC_WP_EN_BIT       0

`endif

/* usmsc_sync.v */
// Two-flop synchroniser with change detection for the four modem inputs.
// Assumes asynchronous pin levels; reports a one-cycle pulse on any change.
`timescale 1ns/1ps
module usmsc_sync
(
    // Clock and reset.
    input  wire       mclk,
    input  wire       reset,
    // Raw pins and results.
    input  wire [3:0] pin_in,
    output wire [3:0] level,
    output wire [3:0] change
);
    reg [3:0] meta_q;
    reg [3:0] sync_q;
    reg [3:0] prev_q;

    // Each bit has its own pair of flops plus a history flop for comparison.
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_bit
            always @(posedge mclk)
            begin
                if (reset)
                begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                    prev_q[i] <= 1'b1;
                end
                else
                begin
                    meta_q[i] <= pin_in[i];
                    sync_q[i] <= meta_q[i];
                    prev_q[i] <= sync_q[i];
                end
            end
            assign change[i] = sync_q[i] ^ prev_q[i];
        end
    endgenerate

    assign level = sync_q;
endmodule

/* usmsc_spi_shift.v */
// Eight-bit SPI shifter for master and slave roles, mode 0 (sample on rising clock).
// Assumes slave-side pins already synchronised to mclk by the caller.
`timescale 1ns/1ps
`include "usmsc_consts.vh"
module usmsc_spi_shift
(
    // Clock and reset.
    input  wire       mclk,
    input  wire       reset,
    // Control.
    input  wire       master,
    input  wire       start,
    input  wire [7:0] tx_byte,
    input  wire [7:0] divisor,
    output reg        busy_q,
    output reg        done_q,
    output reg  [7:0] rx_byte_q,
    // Master pins.
    output reg        sck_q,
    output reg        ss_n_q,
    output wire       mosi,
    input  wire       miso,
    // Slave pins, synchronised.
    input  wire       s_sck,
    input  wire       s_ss_n,
    input  wire       s_mosi,
    output wire       s_miso
);
    reg  [7:0] sh_q;
    reg  [7:0] div_q;
    reg  [3:0] cnt_q;
    reg        s_sck_q;
    wire       rise = s_sck & ~s_sck_q;
    wire       fall = ~s_sck & s_sck_q;

    assign mosi   = sh_q[7];
    assign s_miso = sh_q[7];

    // Master toggles sck once per half bit; slave follows external edges.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            rx_byte_q <= 8'h00;
            sck_q     <= 1'b0;
            ss_n_q    <= 1'b1;
            sh_q      <= 8'h00;
            div_q     <= 8'h00;
            cnt_q     <= 4'h0;
            s_sck_q   <= 1'b0;
        end
        else
        begin
            done_q  <= 1'b0;
            s_sck_q <= s_sck;
            if (master)
            begin
                if (!busy_q && start)
                begin
                    busy_q <= 1'b1;
                    ss_n_q <= 1'b0;
                    sh_q   <= tx_byte;
                    cnt_q  <= 4'h0;
                    div_q  <= divisor;
                end
                else if (busy_q)
                begin
                    if (div_q != 8'h00)
                        div_q <= div_q - 8'h01;
                    else
                    begin
                        div_q <= divisor;
                        if (!sck_q)
                        begin
                            sck_q     <= 1'b1;
                            rx_byte_q <= {rx_byte_q[6:0], miso};
                        end
                        else
                        begin
                            sck_q <= 1'b0;
                            sh_q  <= {sh_q[6:0], 1'b0};
                            if (cnt_q == 4'h7)
                            begin
                                busy_q <= 1'b0;
                                done_q <= 1'b1;
                                ss_n_q <= 1'b1;
                            end
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
            end
            else
            begin
                ss_n_q <= 1'b1;
                sck_q  <= 1'b0;
                if (s_ss_n)
                begin
                    busy_q <= 1'b0;
                    cnt_q  <= 4'h0;
                    if (start)
                        sh_q <= tx_byte;
                end
                else if (rise)
                begin
                    busy_q    <= 1'b1;
                    rx_byte_q <= {rx_byte_q[6:0], s_mosi};
                end
                else if (fall)
                begin
                    sh_q <= {sh_q[6:0], 1'b0};
                    if (cnt_q == 4'h7)
                    begin
                        done_q <= 1'b1;
                        cnt_q  <= 4'h0;
                    end
                    else
                        cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule

/* usmsc_core.v */
// Modem-handshake, SPI mode and gap register of a serial controller, Avalon-MM slave.
// Assumes an Avalon-MM master on mclk; modem and SPI pins are asynchronous.
`timescale 1ns/1ps
`include "usmsc_consts.vh"
// Operation
// - Disable command drives terminal-ready high; enable command drives it low.
// - In modem mode request-to-send is driven by hardware, not software.
// - Any level change on ring, set-ready, carrier or clear-to-send sets a flag.
// - The four change flags clear when the status register is read.
// - Clear-to-send inactive disables the transmitter.
// - A character in progress completes before the transmitter stops.
// - Mode 0xE selects SPI master; SPI slave is also supported.
// - SPI master drives one slave-select output only.
// - Slave is selected only while slave-select is asserted.
// - Master drives the serial clock, one cycle per bit, selectable rate.
// - Master shifts data out on MOSI; slave returns data on MISO.
// - The gap register acts only while mode is 0x9.
// - Gap register writes are ignored while write protection is on.
// - Gap field is bits 23:0, resets to zero, counts bit times.
module usmsc_core
(
    // Clock and reset.
    input  wire        mclk,
    input  wire        reset,
    // Avalon-MM slave.
    input  wire [7:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // Modem pins.
    output reg         terminal_ready_n,
    output reg         rts_n,
    input  wire        ri_n,
    input  wire        dsr_n,
    input  wire        dcd_n,
    input  wire        cts_n,
    output wire        txd,
    // SPI pins.
    output wire        spi_sck,
    output wire        slave_select_n,
    output wire        spi_mosi,
    input  wire        spi_miso,
    input  wire        spi_sck_in,
    input  wire        slave_select_n_in,
    input  wire        spi_mosi_in,
    output wire        spi_miso_out,
    output wire        spi_miso_oe_n,
    // Gap state.
    output wire        gap_active
);
    reg  [31:0] mode_q;
    reg         wp_en_q;
    reg  [23:0] gap_q;
    reg  [3:0]  chg_q;
    reg         tx_en_q;
    reg         txd_q;
    reg  [7:0]  tx_hold_q;
    reg         tx_full_q;
    reg  [9:0]  tx_sh_q;
    reg  [3:0]  tx_bits_q;
    reg  [7:0]  tx_div_q;
    reg         tx_busy_q;
    reg  [23:0] gap_cnt_q;
    reg  [7:0]  rx_q;
    reg         rx_rdy_q;
    reg         ack_q;
    reg  [2:0]  s_meta_q;
    reg  [2:0]  s_sync_q;
    reg         spi_start;
    wire [3:0]  lvl;
    wire [3:0]  chg;
    wire [3:0]  mode_f = mode_q[`USMSC_MODE_LSB +: `USMSC_MODE_W];
    wire [7:0]  div_f  = mode_q[`USMSC_DIV_LSB +: `USMSC_DIV_W];
    wire        is_spi = (mode_f == `USMSC_MODE_SPI_MST) || (mode_f == `USMSC_MODE_SPI_SLV);
    wire        is_mst = (mode_f == `USMSC_MODE_SPI_MST);
    wire        is_lonb = (mode_f == `USMSC_MODE_LONB);
    wire        cts_ok = ~lvl[3];
    wire        wr_acc = write & ack_q;
    wire        rd_acc = read & ack_q;
    wire        spi_busy;
    wire        spi_done;
    wire [7:0]  spi_rx;
    wire        ss_int;

    // Every access takes exactly one wait cycle so read data come from a flop.
    assign waitrequest = (read | write) & ~ack_q;

    always @(posedge mclk)
    begin
        if (reset)
            ack_q <= 1'b0;
        else
            ack_q <= (read | write) & ~ack_q;
    end

    // Modem inputs, ordered ring, set-ready, carrier, clear-to-send.
    usmsc_sync u_sync
    (
        .mclk   (mclk),
        .reset  (reset),
        .pin_in ({cts_n, dcd_n, dsr_n, ri_n}),
        .level  (lvl),
        .change (chg)
    );

    // Slave-side SPI pins cross into mclk through two flops before use.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            s_meta_q <= 3'h1;
            s_sync_q <= 3'h1;
        end
        else
        begin
            s_meta_q <= {spi_mosi_in, spi_sck_in, slave_select_n_in};
            s_sync_q <= s_meta_q;
        end
    end

    usmsc_spi_shift u_spi
    (
        .mclk      (mclk),
        .reset     (reset),
        .master    (is_mst),
        .start     (spi_start),
        .tx_byte   (writedata[7:0]),
        .divisor   (div_f),
        .busy_q    (spi_busy),
        .done_q    (spi_done),
        .rx_byte_q (spi_rx),
        .sck_q     (spi_sck),
        .ss_n_q    (ss_int),
        .mosi      (spi_mosi),
        .miso      (spi_miso),
        .s_sck     (s_sync_q[1]),
        .s_ss_n    (s_sync_q[0]),
        .s_mosi    (s_sync_q[2]),
        .s_miso    (spi_miso_out)
    );

    // A single select line means only one slave can be addressed.
    assign slave_select_n = ss_int;
    // Release MISO whenever not selected so other slaves may drive it.
    assign spi_miso_oe_n = ~((mode_f == `USMSC_MODE_SPI_SLV) & ~s_sync_q[0]);

    always @*
    begin
        spi_start = wr_acc & (address == `USMSC_OFF_TXDATA) & is_spi & tx_en_q;
    end

    // Register writes and the modem control state.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            mode_q           <= `USMSC_MODE_RST;
            wp_en_q          <= 1'b0;
            gap_q            <= `USMSC_GAP_RST;
            terminal_ready_n <= 1'b1;
            tx_en_q          <= 1'b0;
            chg_q            <= 4'h0;
        end
        else
        begin
            // Hardware set wins over the clear caused by a status read.
            if (rd_acc && address == `USMSC_OFF_STATUS)
                chg_q <= chg;
            else
                chg_q <= chg_q | chg;
            if (wr_acc)
            begin
                case (address)
                    `USMSC_OFF_CTRL:
                    begin
                        if (writedata[`USMSC_CMD_TR_DIS])
                            terminal_ready_n <= 1'b1;
                        else if (writedata[`USMSC_CMD_TR_EN])
                            terminal_ready_n <= 1'b0;
                        if (writedata[`USMSC_CMD_TXDIS])
                            tx_en_q <= 1'b0;
                        else if (writedata[`USMSC_CMD_TXEN])
                            tx_en_q <= 1'b1;
                    end
                    `USMSC_OFF_MODE:
                        mode_q <= writedata;
                    `USMSC_OFF_GAP:
                        if (!wp_en_q)
                            gap_q <= writedata[`USMSC_GAP_W-1:0];
                    `USMSC_OFF_WPMODE:
                        wp_en_q <= writedata[`USMSC_WP_EN_BIT];
                    default:
                        gap_q <= gap_q;
                endcase
            end
        end
    end

    // Asynchronous character transmitter gated by clear-to-send.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            tx_hold_q <= 8'h00;
            tx_full_q <= 1'b0;
            tx_sh_q   <= 10'h3FF;
            tx_bits_q <= 4'h0;
            tx_div_q  <= 8'h00;
            tx_busy_q <= 1'b0;
            txd_q     <= 1'b1;
            gap_cnt_q <= 24'h00_0000;
        end
        else
        begin
            if (spi_start == 1'b0 && wr_acc && address == `USMSC_OFF_TXDATA && !tx_full_q)
            begin
                tx_hold_q <= writedata[7:0];
                tx_full_q <= 1'b1;
            end
            if (is_spi)
            begin
                tx_busy_q <= 1'b0;
                txd_q     <= 1'b1;
            end
            else if (!tx_busy_q)
            begin
                txd_q <= 1'b1;
                if (gap_cnt_q != 24'h00_0000)
                begin
                    // Gap counts whole bit times after a frame.
                    if (tx_div_q != 8'h00)
                        tx_div_q <= tx_div_q - 8'h01;
                    else
                    begin
                        tx_div_q  <= div_f;
                        gap_cnt_q <= gap_cnt_q - 24'h00_0001;
                    end
                end
                // A new character starts only while clear-to-send is active.
                else if (tx_full_q && tx_en_q && cts_ok)
                begin
                    tx_sh_q   <= {1'b1, tx_hold_q, 1'b0};
                    tx_full_q <= 1'b0;
                    tx_busy_q <= 1'b1;
                    tx_bits_q <= 4'h0;
                    tx_div_q  <= div_f;
                end
            end
            else
            begin
                // Clear-to-send is not checked mid-frame, so the frame always completes.
                txd_q <= tx_sh_q[0];
                if (tx_div_q != 8'h00)
                    tx_div_q <= tx_div_q - 8'h01;
                else
                begin
                    tx_div_q  <= div_f;
                    tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
                    tx_bits_q <= tx_bits_q + 4'h1;
                    if (tx_bits_q == 4'h9)
                    begin
                        tx_busy_q <= 1'b0;
                        gap_cnt_q <= is_lonb ? gap_q : 24'h00_0000;
                    end
                end
            end
        end
    end

    assign txd        = txd_q;
    assign gap_active = gap_cnt_q != 24'h00_0000;

    // Hardware flow in modem mode: request-to-send asserted while enabled transmit work is pending; other modes assert it while the transmitter is enabled.
    always @(posedge mclk)
    begin
        if (reset)
            rts_n <= 1'b1;
        else if (mode_f == `USMSC_MODE_MODEM)
            rts_n <= ~(tx_en_q & (tx_full_q | tx_busy_q));
        else
            rts_n <= ~tx_en_q;
    end

    // Received SPI bytes; the ready flag clears when read, the byte is kept.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            rx_q     <= 8'h00;
            rx_rdy_q <= 1'b0;
        end
        else if (spi_done)
        begin
            rx_q     <= spi_rx;
            rx_rdy_q <= 1'b1;
        end
        else if (rd_acc && address == `USMSC_OFF_TXDATA)
            rx_rdy_q <= 1'b0;
    end

    // Read data flop; unmapped addresses read as zero.
    always @(posedge mclk)
    begin
        if (reset)
            readdata <= 32'h0000_0000;
        else if (read && !ack_q)
        begin
            case (address)
                `USMSC_OFF_MODE:   readdata <= mode_q;
                `USMSC_OFF_GAP:    readdata <= {8'h00, gap_q};
                `USMSC_OFF_WPMODE: readdata <= {31'h0000_0000, wp_en_q};
                `USMSC_OFF_TXDATA: readdata <= {24'h00_0000, rx_q};
                `USMSC_OFF_STATUS:
                    readdata <= {7'h00, rx_rdy_q, lvl, chg_q | chg, 6'h00,
                                 ~(tx_busy_q | tx_full_q | spi_busy), 7'h00, ~tx_full_q, 1'b0};
                default:           readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

/* usmsc_core_chk.sv */
// Checker for the modem, SPI and gap block, watching only its ports.
// Assumes binding to usmsc_core; mode and enable are shadowed from bus writes.
`timescale 1ns/1ps
`include "usmsc_consts.vh"
module usmsc_chk
(
    // Clock and reset.
    input wire        mclk,
    input wire        reset,
    // Bus side.
    input wire [7:0]  address,
    input wire        write,
    input wire [31:0] writedata,
    input wire        waitrequest,
    // Pins.
    input wire        terminal_ready_n,
    input wire        rts_n,
    input wire        spi_sck,
    input wire        slave_select_n,
    input wire        slave_select_n_in,
    input wire        spi_miso_oe_n,
    input wire        gap_active
);
    reg  [3:0] mode_q;
    reg        txen_q;
    wire       wr_ok = write && !waitrequest;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Shadow state changes only on the edge where a write takes effect.
    always @(posedge mclk)
    begin
        if (reset)
        begin
            mode_q <= 4'h0;
            txen_q <= 1'b0;
        end
        else if (wr_ok && address == `USMSC_OFF_MODE)
            mode_q <= writedata[3:0];
        else if (wr_ok && address == `USMSC_OFF_CTRL && (writedata[6] || writedata[7]))
            txen_q <= !writedata[7];
    end
    // Command steps and deselection, as named sequences.
    sequence s_cmd(b); wr_ok && address == `USMSC_OFF_CTRL && writedata[b]; endsequence
    sequence s_desel; slave_select_n_in [*4]; endsequence
    property p_tr_on; s_cmd(16) ##0 !writedata[17] |-> ##[1:2] !terminal_ready_n; endproperty
    a_tr_on: assert property (p_tr_on) else $error("terminal ready not driven low");
    property p_tr_off; s_cmd(17) |-> ##[1:2] terminal_ready_n; endproperty
    a_tr_off: assert property (p_tr_off) else $error("terminal ready not driven high");
    property p_rts; !rts_n |-> txen_q || $past(txen_q); endproperty
    a_rts: assert property (p_rts) else $error("request to send without enable");
    property p_gap_mode; gap_active |-> mode_q == `USMSC_MODE_LONB; endproperty
    a_gap_mode: assert property (p_gap_mode) else $error("gap outside gap mode");
    property p_spi_mode; $changed(spi_sck) |-> mode_q == `USMSC_MODE_SPI_MST; endproperty
    a_spi_mode: assert property (p_spi_mode) else $error("serial clock outside master");
    property p_sck_frame; spi_sck |-> !slave_select_n; endproperty
    a_sck_frame: assert property (p_sck_frame) else $error("clock while deselected");
    property p_oe_mode; !spi_miso_oe_n |-> mode_q == `USMSC_MODE_SPI_SLV; endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("data out driven outside slave");
    property p_desel; s_desel |-> spi_miso_oe_n; endproperty
    a_desel: assert property (p_desel) else $error("data out driven while deselected");
endmodule
bind usmsc_core usmsc_chk chk_u (.mclk(mclk), .reset(reset), .address(address),
    .write(write), .writedata(writedata), .waitrequest(waitrequest),
    .terminal_ready_n(terminal_ready_n), .rts_n(rts_n), .spi_sck(spi_sck),
    .slave_select_n(slave_select_n), .slave_select_n_in(slave_select_n_in),
    .spi_miso_oe_n(spi_miso_oe_n), .gap_active(gap_active));

/* usmsc_peer.sv */
// Behavioural SPI slave on the far side of the master pins.
// Assumes mode 0, eight bits MSB first, select active low.
`timescale 1ns/1ps
module usmsc_peer
(
    // Master-driven lines.
    input  wire       sck,
    input  wire       ss_n,
    input  wire       mosi,
    // Reply byte and observations.
    input  wire [7:0] tx_byte,
    output reg        miso = 1'b0,
    output reg  [7:0] rx_q = 8'h00,
    output reg  [7:0] edges_q = 8'h00
);
    reg [7:0] sh_q = 8'h00;
    // Selection loads the reply and presents its first bit before any clock.
    always @(negedge ss_n)
    begin
        sh_q    <= tx_byte;
        miso    <= tx_byte[7];
        edges_q <= 8'h00;
    end
    // Sample on the rising edge, only while selected.
    always @(posedge sck)
        if (!ss_n)
        begin
            rx_q    <= {rx_q[6:0], mosi};
            edges_q <= edges_q + 8'h01;
        end
    // Shift out on the falling edge.
    always @(negedge sck)
        if (!ss_n)
        begin
            miso <= sh_q[6];
            sh_q <= {sh_q[6:0], 1'b0};
        end
    // Released line shows the inverse, so a stale bit never passes for data.
    always @(posedge ss_n)
        miso <= ~miso;
endmodule

/* test_usart_modem_spi_control.sv */
// Self-checking bench for the modem, SPI and gap block over Avalon-MM.
// Assumes usmsc_core, usmsc_peer and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "usmsc_consts.vh"
module test_usart_modem_spi_control;
    reg         mclk = 1'b0;
    reg         reset = 1'b1;
    reg  [7:0]  address = 8'h00;
    reg         read = 1'b0;
    reg         write = 1'b0;
    reg  [31:0] writedata = 32'h0;
    reg  [3:0]  mdm = 4'b0111; // Clear-to-send, carrier, set-ready, ring.
    reg         sck_in = 1'b0;
    reg         ss_in = 1'b1;
    reg         mosi_in = 1'b0;
    reg  [7:0]  peer_tx = 8'h00;
    wire [31:0] readdata;
    wire        waitrequest, terminal_ready_n, rts_n, txd, spi_sck, slave_select_n;
    wire        spi_mosi, spi_miso, spi_miso_out, spi_miso_oe_n, gap_active;
    wire [7:0]  peer_rx, peer_edges;
    integer     fails = 0, comparisons = 0, cycles = 0, gap_cyc = 0, txd_lows = 0, i;
    reg  [31:0] q, d;
    reg  [7:0]  b, got;
    reg         oe_mid;
    usmsc_core dut_u (.mclk(mclk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .terminal_ready_n(terminal_ready_n), .rts_n(rts_n),
        .ri_n(mdm[0]), .dsr_n(mdm[1]), .dcd_n(mdm[2]), .cts_n(mdm[3]), .txd(txd),
        .spi_sck(spi_sck), .slave_select_n(slave_select_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_sck_in(sck_in), .slave_select_n_in(ss_in),
        .spi_mosi_in(mosi_in), .spi_miso_out(spi_miso_out),
        .spi_miso_oe_n(spi_miso_oe_n), .gap_active(gap_active));
    usmsc_peer peer_u (.sck(spi_sck), .ss_n(slave_select_n), .mosi(spi_mosi),
        .tx_byte(peer_tx), .miso(spi_miso), .rx_q(peer_rx), .edges_q(peer_edges));
    always #2.5 mclk = ~mclk;
    // Watchdog and line monitors; the main flow only reads their counts.
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        txd_lows <= txd_lows + (txd === 1'b0);
        gap_cyc <= gap_cyc + (gap_active === 1'b1);
        if (cycles == 20000)
        begin
            fails = fails + 1;
            results;
        end
    end
    task results;
    begin
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task chk(input [31:0] g, input [31:0] e, input string m);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    end
    endtask
    // One bus cycle held until waitrequest is seen low; read data lands in q.
    task bus(input w, input [7:0] a, input [31:0] v);
    begin
        @(posedge mclk);
        write <= w;
        read <= !w;
        address <= a;
        writedata <= v;
        @(posedge mclk);
        while (waitrequest !== 1'b0) @(posedge mclk);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    end
    endtask
    // The 64 ns link clock runs only inside the frame.
    task slave_frame(input [7:0] v);
    begin
        #1.7 ss_in <= 1'b0;
        for (i = 7; i >= 0; i = i - 1)
        begin
            mosi_in <= v[i];
            #32 sck_in <= 1'b1;
            got[i] = spi_miso_out;
            if (i == 3) oe_mid = spi_miso_oe_n;
            #32 sck_in <= 1'b0;
        end
        #32 ss_in <= 1'b1;
    end
    endtask
    initial
    begin
        q = $urandom(32'hC98DBA88);
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        bus(0, `USMSC_OFF_GAP, 0);
        chk(q, 0, "gap reset");
        bus(1, `USMSC_OFF_CTRL, 32'h0001_0000);
        bus(0, `USMSC_OFF_STATUS, 0);
        chk(terminal_ready_n, 0, "tr enable");
        bus(1, `USMSC_OFF_CTRL, 32'h0002_0000);
        bus(0, `USMSC_OFF_STATUS, 0);
        chk(terminal_ready_n, 1, "tr disable");
        d = $urandom;
        bus(1, `USMSC_OFF_GAP, d);
        bus(0, `USMSC_OFF_GAP, 0);
        chk(q, d & 32'h00FF_FFFF, "gap rw");
        bus(1, `USMSC_OFF_WPMODE, 32'h1);
        bus(1, `USMSC_OFF_GAP, ~d);
        bus(0, `USMSC_OFF_GAP, 0);
        chk(q, d & 32'h00FF_FFFF, "gap locked");
        bus(1, `USMSC_OFF_WPMODE, 32'h0);
        bus(0, 8'h40, 0);
        chk(q, 0, "unmapped");
        $display("Test registers done");
        // Each modem pin toggles both ways; flags set, then clear on read.
        bus(0, `USMSC_OFF_STATUS, 0);
        for (i = 0; i < 8; i = i + 1)
        begin
            mdm[i%4] <= ~mdm[i%4];
            repeat (8) @(posedge mclk);
            bus(0, `USMSC_OFF_STATUS, 0);
            chk(q[23:16], {mdm, 4'b0001 << (i % 4)}, "change set");
            bus(0, `USMSC_OFF_STATUS, 0);
            chk(q[19:16], 0, "change clr");
        end
        $display("Test modem done");
        for (i = 0; i < 4; i = i + 1)
        begin
            d = $urandom;
            b = (i == 0) ? 8'h80 : d[7:0];
            peer_tx <= (i == 1) ? 8'h01 : d[15:8];
            bus(1, `USMSC_OFF_MODE, {16'h0, 6'h0, d[17:16], 4'h0, `USMSC_MODE_SPI_MST});
            bus(1, `USMSC_OFF_CTRL, 32'h40);
            bus(1, `USMSC_OFF_TXDATA, {24'h0, b});
            q = 0;
            while (q[24] !== 1'b1) bus(0, `USMSC_OFF_STATUS, 0);
            bus(0, `USMSC_OFF_TXDATA, 0);
            chk(q[7:0], peer_tx, "miso byte");
            chk(peer_rx, b, "mosi byte");
            chk(peer_edges, 8, "sck count");
        end
        $display("Test master done");
        bus(1, `USMSC_OFF_MODE, `USMSC_MODE_SPI_SLV);
        d = $urandom;
        bus(1, `USMSC_OFF_TXDATA, {24'h0, d[7:0]});
        slave_frame(d[15:8]);
        repeat (8) @(posedge mclk);
        chk(oe_mid, 0, "oe selected");
        chk(spi_miso_oe_n, 1, "oe released");
        chk(got, d[7:0], "slave miso");
        bus(0, `USMSC_OFF_TXDATA, 0);
        chk(q[7:0], d[15:8], "slave mosi");
        $display("Test slave done");
        // Modem mode, bit of 4 cycles: held by inactive clear-to-send.
        b = d[23:16];
        bus(1, `USMSC_OFF_MODE, {16'h0, 8'h03, 4'h0, `USMSC_MODE_MODEM});
        mdm[3] <= 1'b1;
        bus(1, `USMSC_OFF_CTRL, 32'h40);
        bus(1, `USMSC_OFF_TXDATA, {24'h0, b});
        i = txd_lows;
        repeat (100) @(posedge mclk);
        chk(txd_lows, i, "cts holds tx");
        chk(rts_n, 0, "rts pending");
        mdm[3] <= 1'b0;
        while (txd !== 1'b0) @(posedge mclk);
        mdm[3] <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 8; i = i + 1)
        begin
            repeat (4) @(posedge mclk);
            got[i] = txd;
        end
        chk(got, b, "char completes");
        repeat (8) @(posedge mclk);
        bus(1, `USMSC_OFF_GAP, 32'h5);
        bus(1, `USMSC_OFF_MODE, {16'h0, 8'h03, 4'h0, `USMSC_MODE_LONB});
        mdm[3] <= 1'b0;
        i = gap_cyc;
        bus(1, `USMSC_OFF_TXDATA, {24'h0, b});
        repeat (120) @(posedge mclk);
        chk(gap_cyc - i, 20, "gap length");
        $display("Test transmit done");
        results;
    end
endmodule
